// file: logic/buck_startup_shutdown_sequencer.sv
// start-up, shutdown and current clamp sequencer of the buck converter
`include "seq_map.svh"
module buck_startup_shutdown_sequencer #(
    parameter int                 INIT_CYCLES  = `INIT_US * `CLK_MHZ,
    parameter logic [15:0]        HICCUP_US    = 16'(`HICCUP_MS * 1000),
    parameter logic signed [15:0] SINK_LIMIT_0 = 16'shFC00,
    parameter logic signed [15:0] SINK_LIMIT_1 = 16'shF800
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               run_pin,
    input  wire seq_pkg::reg_req_t  req,
    output      logic               reg_ack,
    output      logic [15:0]        reg_rdata,
    input  wire logic [2:0]         strap_select_a,
    input  wire logic [1:0]         strap_select_b,
    input  wire logic [7:0]         frequency_setting_reg,
    input  wire logic               freq_reg_valid,
    input  wire logic               forced_continuous_bit,
    input  wire logic               sink_limit_select,
    input  wire logic [7:0]         undervoltage_response_setting,
    input  wire logic [15:0]        boot_voltage,
    input  wire logic [15:0]        target_voltage_setting,
    input  wire logic [15:0]        vout_mv,
    input  wire logic [15:0]        fb_mv,
    input  wire logic               pwm_request,
    input  wire logic signed [15:0] ls_current,
    input  wire logic signed [15:0] valley_current_clamp,
    input  wire logic               undervoltage_fault,
    input  wire logic               status_clear,
    output      seq_pkg::gate_t     gate,
    output      logic [15:0]        ref_mv,
    output      logic [7:0]         current_status_reg,
    output      logic [7:0]         freq_select,
    output      logic               continuous_mode,
    output      logic               init_done,
    output      seq_pkg::seq_state_t seq_state
);
    import seq_pkg::*;

    localparam int US_CYC = `CLK_MHZ;
    localparam int DG_CYC = `DEGLITCH_CYC;

    seq_state_t  state;
    seq_state_t  next_state;
    logic [31:0] init_cnt;
    logic [7:0]  us_cnt;
    logic        tick;
    logic [15:0] t_us;
    logic [15:0] uv_us;
    logic [7:0]  dg_cnt;
    logic        run_f;
    logic        run_prev;
    logic        run_fall;
    logic        run_req;
    logic [7:0]  on_off_command;
    logic [7:0]  enable_source_setup;
    logic [15:0] power_on_wait;
    logic [15:0] ramp_up_time;
    logic [15:0] power_off_wait;
    logic [15:0] ramp_down_time;
    logic        rise_written;
    logic [31:0] ref_acc;
    logic [31:0] next_ref;
    logic        first_hs;
    gate_t       next_gate;

    // supply good is the reset, so init counts from its release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_cnt <= 32'h0;
            init_done <= 1'b0;
        end else if (state == ST_INIT) begin
            init_cnt <= init_cnt + 32'h1;
            init_done <= 1'b0;
        end else begin
            init_done <= 1'b1;
        end
    end

    wire init_end = init_cnt >= 32'(INIT_CYCLES - 1);

    assign tick = us_cnt == 8'(US_CYC - 1);
    // prescaler restarts with each state, so a timed period is never a tick short
    wire us_restart = tick | (next_state != state);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            us_cnt <= 8'h0;
        end else begin
            us_cnt <= us_restart ? 8'h0 : us_cnt + 8'h1;
        end
    end

    // a level must persist the full window before it is believed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dg_cnt <= 8'h0;
            run_f <= 1'b0;
            run_prev <= 1'b0;
        end else begin
            run_prev <= run_f;
            if (run_pin == run_f) begin
                dg_cnt <= 8'h0;
            end else if (dg_cnt == 8'(DG_CYC - 1)) begin
                dg_cnt <= 8'h0;
                run_f <= run_pin;
            end else begin
                dg_cnt <= dg_cnt + 8'h1;
            end
        end
    end

    assign run_fall = run_prev & ~run_f;
    assign run_req = (~enable_source_setup[`B_EN_PIN] | run_f)
                   & (~enable_source_setup[`B_EN_CMD] | on_off_command[`B_CMD_ON]);

    // register port; nothing is answered during init
    wire wr_ok = req.wr & init_done;
    wire rd_ok = req.rd & init_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_off_command <= `RST_ON_OFF;
            enable_source_setup <= `RST_EN_SRC;
            power_on_wait <= `RST_ON_WAIT;
            ramp_up_time <= `RST_RISE;
            power_off_wait <= `RST_OFF_WAIT;
            ramp_down_time <= `RST_FALL;
            rise_written <= 1'b0;
        end else if (wr_ok) begin
            case (req.addr)
                `A_ON_OFF: on_off_command <= req.wdata[7:0];
                `A_EN_SRC: enable_source_setup <= req.wdata[7:0];
                `A_ON_WAIT: power_on_wait <= req.wdata;
                `A_RISE: begin
                    ramp_up_time <= req.wdata;
                    rise_written <= 1'b1;
                end
                `A_OFF_WAIT: power_off_wait <= req.wdata;
                `A_FALL: ramp_down_time <= req.wdata;
                default: ;
            endcase
        end
    end

    logic [15:0] rd_mux;
    always_comb begin
        case (req.addr)
            `A_ON_OFF: rd_mux = {8'h0, on_off_command};
            `A_EN_SRC: rd_mux = {8'h0, enable_source_setup};
            `A_ON_WAIT: rd_mux = power_on_wait;
            `A_RISE: rd_mux = ramp_up_time;
            `A_OFF_WAIT: rd_mux = power_off_wait;
            `A_FALL: rd_mux = ramp_down_time;
            default: rd_mux = 16'h0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_ack <= 1'b0;
            reg_rdata <= 16'h0;
        end else begin
            reg_ack <= wr_ok | rd_ok;
            reg_rdata <= rd_ok ? rd_mux : 16'h0;
        end
    end

    // delay and ramp lengths in microseconds
    wire [15:0] on_units = power_on_wait == 16'h0 ? 16'h1
                         : power_on_wait > 16'(`WAIT_MAX) ? 16'(`WAIT_MAX) : power_on_wait;
    wire [15:0] off_units = power_off_wait == 16'h0 ? 16'h1
                          : power_off_wait > 16'(`WAIT_MAX) ? 16'(`WAIT_MAX) : power_off_wait;
    wire [15:0] on_wait_us = 16'(on_units * 16'(`WAIT_LSB_US));
    wire [15:0] off_wait_us = 16'(off_units * 16'(`WAIT_LSB_US));

    // once software writes the ramp time it overrides the strap
    wire [2:0] rise_sel = rise_written ? ramp_up_time[2:0] : strap_select_a;
    wire [2:0] rise_code = rise_sel > 3'(`RISE_MAXCODE) ? 3'(`RISE_MAXCODE) : rise_sel;
    wire [15:0] rise_us = 16'(`RISE_BASE_US) << rise_code;
    wire [1:0] fall_code = ramp_down_time[1:0];
    wire [15:0] fall_us = 16'(`FALL_BASE_US) << fall_code;

    wire [15:0] target = on_off_command[`B_USE_TARGET] ? target_voltage_setting
                                                      : boot_voltage;
    wire [31:0] full_ref = {target, 16'h0};
    wire [31:0] step_up = full_ref / {16'h0, rise_us};
    // slope fixed by boot level, so total stop time varies with the reference the ramp starts from
    wire [31:0] step_dn = {boot_voltage, 16'h0} / {16'h0, fall_us};
    wire [31:0] sum_up = ref_acc + step_up;

    assign ref_mv = ref_acc[31:16];

    // undervoltage delay, live only in regulation
    wire [15:0] uv_delay_us = 16'({13'h0, undervoltage_response_setting[2:0]}
                                  * 16'(`UV_LSB_US));
    wire uv_live = state == ST_REGULATE;
    wire uv_trip = uv_live & undervoltage_fault & (uv_us >= uv_delay_us);
    wire uv_restart = undervoltage_response_setting[`B_UV_RESTART];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uv_us <= 16'h0;
        end else if (!(uv_live && undervoltage_fault)) begin
            uv_us <= 16'h0;
        end else if (tick && uv_us != 16'hFFFF) begin
            uv_us <= uv_us + 16'h1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_INIT: begin
                if (init_end) next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (run_req) next_state = ST_ON_WAIT;
            end
            ST_ON_WAIT: begin
                if (!run_req) next_state = ST_IDLE;
                else if (t_us >= on_wait_us) next_state = ST_RAMP_UP;
            end
            ST_RAMP_UP: begin
                if (!run_req) next_state = ST_OFF_WAIT;
                else if (t_us >= rise_us) next_state = ST_REGULATE;
            end
            ST_REGULATE: begin
                if (uv_trip) next_state = uv_restart ? ST_HICCUP : ST_LATCHED;
                else if (!run_req) next_state = ST_OFF_WAIT;
            end
            ST_OFF_WAIT: begin
                if (run_req) next_state = ST_REGULATE;
                else if (t_us >= off_wait_us) next_state = ST_RAMP_DOWN;
            end
            ST_RAMP_DOWN: begin
                if (vout_mv <= 16'(`STOP_MV)) next_state = ST_IDLE;
            end
            ST_HICCUP: begin
                if (t_us >= HICCUP_US) next_state = ST_IDLE;
            end
            ST_LATCHED: begin
                if (run_fall) next_state = ST_IDLE;
            end
            default: next_state = ST_INIT;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_INIT;
            t_us <= 16'h0;
        end else begin
            state <= next_state;
            if (next_state != state) t_us <= 16'h0;
            else if (tick && t_us != 16'hFFFF) t_us <= t_us + 16'h1;
        end
    end

    assign seq_state = state;

    always_comb begin
        case (state)
            ST_RAMP_UP: begin
                if (t_us >= rise_us || sum_up > full_ref) next_ref = full_ref;
                else if (tick) next_ref = sum_up;
                else next_ref = ref_acc;
            end
            ST_REGULATE: next_ref = full_ref;
            ST_OFF_WAIT: next_ref = ref_acc;
            ST_RAMP_DOWN: begin
                if (!tick) next_ref = ref_acc;
                else if (ref_acc > step_dn) next_ref = ref_acc - step_dn;
                else next_ref = 32'h0;
            end
            default: next_ref = 32'h0;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) ref_acc <= 32'h0;
        else ref_acc <= next_ref;
    end

    // power stage gating
    wire switching = state == ST_RAMP_UP || state == ST_REGULATE
                  || state == ST_OFF_WAIT || state == ST_RAMP_DOWN;
    wire valley_hold = ls_current > valley_current_clamp;
    wire signed [15:0] sink_lim = sink_limit_select ? SINK_LIMIT_1 : SINK_LIMIT_0;
    wire sink_trip = ls_current < sink_lim;
    // until the first pulse the reference must clear the prebiased feedback
    wire hs_permit = state != ST_RAMP_UP || first_hs || ref_mv > fb_mv;

    always_comb begin
        next_gate.high_side = switching & hs_permit & pwm_request & ~valley_hold;
        next_gate.low_side = switching & first_hs & ~next_gate.high_side
                           & (valley_hold | ~pwm_request) & ~sink_trip;
        next_gate.tristate = ~switching;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gate <= '{high_side: 1'b0, low_side: 1'b0, tristate: 1'b1};
            first_hs <= 1'b0;
        end else begin
            gate <= next_gate;
            if (!switching) first_hs <= 1'b0;
            else if (gate.high_side) first_hs <= 1'b1;
        end
    end

    // sticky clamp flag, a fresh clamp beats a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            current_status_reg <= 8'h0;
        end else if (switching && valley_hold) begin
            current_status_reg[`B_CLAMP] <= 1'b1;
        end else if (status_clear) begin
            current_status_reg[`B_CLAMP] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freq_select <= 8'h0;
            continuous_mode <= 1'b0;
        end else begin
            freq_select <= freq_reg_valid ? frequency_setting_reg
                                          : {6'h0, strap_select_b};
            continuous_mode <= forced_continuous_bit;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_init_length: assert property (
        state == ST_INIT && next_state != ST_INIT |-> init_cnt >= 32'(INIT_CYCLES - 1))
        else $error("init left early");

    a_bus_gated: assert property (
        !init_done |=> !reg_ack)
        else $error("register answer before init done");

    a_on_wait_len: assert property (
        state == ST_ON_WAIT ##1 state == ST_RAMP_UP |-> $past(t_us) >= $past(on_wait_us))
        else $error("ramp began before turn-on delay");

    a_ramp_from_zero: assert property (
        $past(state) == ST_ON_WAIT && state == ST_RAMP_UP |-> ref_mv == 16'h0)
        else $error("soft-start did not begin at zero");

    a_prebias_low: assert property (
        gate.low_side |-> $past(first_hs))
        else $error("low side before first high-side pulse");

    a_prebias_high: assert property (
        state == ST_RAMP_UP && !first_hs && ref_mv <= fb_mv |=> !gate.high_side)
        else $error("high side before reference passed feedback");

    a_stop_tristate: assert property (
        state == ST_RAMP_DOWN && vout_mv <= 16'(`STOP_MV) |-> ##2 gate.tristate)
        else $error("stage not tristated after soft-stop");

    a_valley_hold: assert property (
        switching && valley_hold |=> !gate.high_side)
        else $error("high side during valley clamp");

    a_clamp_flag: assert property (
        switching && valley_hold |=> current_status_reg[`B_CLAMP])
        else $error("clamp flag not set");

    a_uv_masked: assert property (
        state == ST_RAMP_UP |-> uv_us == 16'h0 && !uv_trip)
        else $error("undervoltage active in soft-start");

    a_sink_off: assert property (
        sink_trip |=> !gate.low_side)
        else $error("low side on past sink limit");

    a_latch_hold: assert property (
        state == ST_LATCHED && !run_fall |=> state == ST_LATCHED)
        else $error("latch-off released without toggle");

    a_hiccup_len: assert property (
        state == ST_HICCUP && t_us < HICCUP_US |=> state == ST_HICCUP)
        else $error("hiccup ended early");

    a_run_glitch: assert property (
        run_pin != run_f && dg_cnt < 8'(DG_CYC - 1) |=> $stable(run_f))
        else $error("short run pulse passed the filter");

endmodule : buck_startup_shutdown_sequencer

// file: logic/seq_map.svh
// register map, field positions, reset values and timing constants of the sequencer
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH
`define A_ON_OFF     8'h01
`define A_EN_SRC     8'h02
`define A_ON_WAIT    8'h60
`define A_RISE       8'h61
`define A_OFF_WAIT   8'h64
`define A_FALL       8'h65
`define RST_ON_OFF   8'h80
`define RST_EN_SRC   8'h02
`define RST_ON_WAIT  16'h0001
`define RST_RISE     16'h0000
`define RST_OFF_WAIT 16'h0001
`define RST_FALL     16'h0000
`define B_CMD_ON     7
`define B_USE_TARGET 0
`define B_EN_CMD     0
`define B_EN_PIN     1
`define B_UV_RESTART 3
`define B_CLAMP      0
`define CLK_MHZ      125
`define INIT_US      200
`define DEGLITCH_NS  200
`define DEGLITCH_CYC ((`DEGLITCH_NS*`CLK_MHZ+999)/1000)
`define WAIT_LSB_US  50
`define WAIT_MAX     40
`define RISE_BASE_US 1000
`define RISE_MAXCODE 4
`define FALL_BASE_US 500
`define FALL_MAXCODE 3
`define STOP_MV      200
`define HICCUP_MS    56
`define UV_LSB_US    128
`endif

// file: logic/seq_pkg.sv
// types shared by the start-up and shutdown sequencer
package seq_pkg;
    typedef enum logic [3:0] {
        ST_INIT      = 4'h0,
        ST_IDLE      = 4'h1,
        ST_ON_WAIT   = 4'h3,
        ST_RAMP_UP   = 4'h2,
        ST_REGULATE  = 4'h6,
        ST_OFF_WAIT  = 4'h7,
        ST_RAMP_DOWN = 4'h5,
        ST_HICCUP    = 4'h4,
        ST_LATCHED   = 4'hC
    } seq_state_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic high_side;
        logic low_side;
        logic tristate;
    } gate_t;
endpackage : seq_pkg

// file: verification/host_model.sv
// host model: register accesses and run pin drive toward the sequencer
module host_model (
    input  wire logic              clk,
    input  wire logic              init_done,
    input  wire logic              reg_ack,
    input  wire logic [15:0]       reg_rdata,
    output      seq_pkg::reg_req_t req,
    output      logic              run_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    import seq_pkg::*;
    initial begin
        req     = '0;
        run_pin = 1'b0;
    end
    // early=1 only to probe refusal before init has finished
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                          input bit early, output logic [15:0] q, output logic ack);
        for (int i = 0; i < 300 && !early && init_done !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        #1;
        req = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk);
        #1;
        ack = reg_ack;
        q   = reg_rdata;
        // released lines show the inverse so stale values are never read as valid
        req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : access
    task automatic set_run(input logic v);
        @(posedge clk);
        #1;
        run_pin = v;
    endtask : set_run
endmodule : host_model

// file: verification/tb_buck_startup_shutdown_sequencer.sv
// self-checking testbench of the start-up and shutdown sequencer
module tb_buck_startup_shutdown_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    import seq_pkg::*;
    localparam int INIT_CYC = 50;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               run_pin, reg_ack, freq_reg_valid, forced_continuous_bit;
    logic               sink_limit_select, undervoltage_fault, status_clear, pwm_request;
    logic               init_done, continuous_mode, ack;
    logic [2:0]         strap_select_a;
    logic [1:0]         strap_select_b;
    logic [7:0]         frequency_setting_reg, undervoltage_response_setting;
    logic [7:0]         current_status_reg, freq_select;
    logic [15:0]        reg_rdata, boot_voltage, target_voltage_setting, vout_mv, fb_mv;
    logic [15:0]        ref_mv, q, r0;
    logic signed [15:0] ls_current, valley_current_clamp;
    reg_req_t           req;
    gate_t              gate;
    seq_state_t         seq_state;
    int                 n_mismatch = 0;
    int                 num_checks = 0;
    int                 cnt;
    bit                 bad, seen_hs;
    logic [7:0]         addrs [6] = '{8'h01, 8'h02, 8'h60, 8'h61, 8'h64, 8'h65};
    logic [15:0]        rstv  [6] = '{16'h0080, 16'h0002, 16'h0001, 16'h0000, 16'h0001, 16'h0000};
    // bit 0 of the on/off word ramps to the programmed target rather than the boot level
    logic [15:0]        cfg   [6] = '{16'h0081, 16'h0002, 16'h0002, 16'h0000, 16'h0001, 16'h0000};

    always #4 clk = ~clk;

    buck_startup_shutdown_sequencer #(.INIT_CYCLES(INIT_CYC), .HICCUP_US(16'h0004)) dut (
        .clk, .rst, .run_pin, .req, .reg_ack, .reg_rdata, .strap_select_a, .strap_select_b,
        .frequency_setting_reg, .freq_reg_valid, .forced_continuous_bit, .sink_limit_select,
        .undervoltage_response_setting, .boot_voltage, .target_voltage_setting, .vout_mv,
        .fb_mv, .pwm_request, .ls_current, .valley_current_clamp, .undervoltage_fault,
        .status_clear, .gate, .ref_mv, .current_status_reg, .freq_select, .continuous_mode,
        .init_done, .seq_state);

    host_model host (.clk, .init_done, .reg_ack, .reg_rdata, .req, .run_pin);

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    // a wait that runs out of its bound ends the run
    task automatic wait_state(input seq_state_t s, input int lim, output int n);
        n = 0;
        while (seq_state !== s) begin
            cycles(1);
            n++;
            if (n > lim) begin
                check("state wait", 16'(seq_state), 16'(s));
                finish_test();
            end
        end
    endtask : wait_state

    initial begin
        {freq_reg_valid, forced_continuous_bit, sink_limit_select} = 3'h0;
        {undervoltage_fault, status_clear, pwm_request} = 3'h0;
        strap_select_a = 3'h0;
        strap_select_b = 2'h0;
        frequency_setting_reg = 8'h00;
        undervoltage_response_setting = 8'h08;
        boot_voltage = 16'h03E8;
        target_voltage_setting = 16'h0320;
        vout_mv = 16'h0384;
        fb_mv = 16'h000A;
        ls_current = 16'sh0000;
        valley_current_clamp = 16'sh012C;
        cycles(12);
        rst = 1'b0;
        host.access(1'b1, 8'h60, 16'h0007, 1'b1, q, ack);
        check("early ack", 16'(ack), 16'h0000);
        cnt = 2;
        while (init_done !== 1'b1 && cnt < 300) begin
            cycles(1);
            cnt++;
        end
        check("init length", 16'(cnt >= INIT_CYC - 1 && cnt <= INIT_CYC + 3), 16'h0001);
        for (int i = 0; i < 6; i++) begin
            host.access(1'b0, addrs[i], 16'h0000, 1'b0, q, ack);
            check("reset value", q, rstv[i]);
            host.access(1'b1, addrs[i], 16'hA5C3, 1'b0, q, ack);
            host.access(1'b0, addrs[i], 16'h0000, 1'b0, q, ack);
            check("readback", q, (i < 2) ? 16'h00C3 : 16'hA5C3);
            check("read ack", 16'(ack), 16'h0001);
            host.access(1'b1, addrs[i], cfg[i], 1'b0, q, ack);
        end
        host.access(1'b0, 8'h30, 16'h0000, 1'b0, q, ack);
        check("unmapped read", {ack, q[14:0]}, 16'h8000);
        $display("test registers done");
        for (int b = 0; b < 4; b++) begin
            strap_select_b = 2'(b);
            forced_continuous_bit = b[0];
            freq_reg_valid = b[1];
            frequency_setting_reg = 8'h5A;
            cycles(2);
            check("freq", 16'(freq_select), b[1] ? 16'h005A : 16'(b));
            check("ccm", 16'(continuous_mode), 16'(b[0]));
        end
        $display("test frequency done");
        host.set_run(1'b1);
        cycles(18);
        host.set_run(1'b0);
        cycles(40);
        check("glitch", 16'(seq_state), 16'(ST_IDLE));
        host.set_run(1'b1);
        wait_state(ST_ON_WAIT, 40, cnt);
        wait_state(ST_RAMP_UP, 13000, cnt);
        check("on wait", 16'(cnt >= 12490 && cnt <= 12510), 16'h0001);
        check("ramp start", ref_mv, 16'h0000);
        // prebiased output: neither switch before the reference passes feedback
        pwm_request = 1'b1;
        undervoltage_fault = 1'b1;
        bad = 0;
        seen_hs = 0;
        for (int i = 0; i < 3000 && !seen_hs; i++) begin
            cycles(1);
            if (gate.high_side === 1'b1) seen_hs = 1;
            else if (gate.low_side !== 1'b0) bad = 1;
            if (gate.high_side === 1'b1 && ref_mv <= fb_mv) bad = 1;
        end
        check("prebias hold", 16'(bad), 16'h0000);
        check("first pulse", 16'(seen_hs), 16'h0001);
        r0 = ref_mv;
        cycles(12500);
        check("rise slope", 16'((ref_mv - r0) inside {[16'h4F:16'h51]}), 16'h0001);
        check("uv ignored", 16'(seq_state), 16'(ST_RAMP_UP));
        undervoltage_fault = 1'b0;
        ls_current = 16'sh01F4;
        cycles(3);
        check("clamp flag", 16'(current_status_reg), 16'h0001);
        check("clamp gate", 16'({gate.high_side, gate.low_side}), 16'h0001);
        ls_current = 16'sh0000;
        status_clear = 1'b1;
        cycles(1);
        status_clear = 1'b0;
        cycles(1);
        check("clamp clear", 16'(current_status_reg), 16'h0000);
        pwm_request = 1'b0;
        cycles(3);
        check("low side on", 16'(gate.low_side), 16'h0001);
        ls_current = -16'sh0500;
        cycles(3);
        check("sink limit", 16'(gate.low_side), 16'h0000);
        sink_limit_select = 1'b1;
        cycles(3);
        check("sink limit sel", 16'(gate.low_side), 16'h0001);
        ls_current = -16'sh0900;
        cycles(3);
        check("sink limit 1", 16'(gate.low_side), 16'h0000);
        sink_limit_select = 1'b0;
        ls_current = 16'sh0000;
        $display("test start-up done");
        host.set_run(1'b0);
        wait_state(ST_OFF_WAIT, 40, cnt);
        wait_state(ST_RAMP_DOWN, 6400, cnt);
        check("off wait", 16'(cnt >= 6240 && cnt <= 6260), 16'h0001);
        r0 = ref_mv;
        cycles(1250);
        // slope follows the boot level even though the ramp went to the target
        check("fall slope", 16'((r0 - ref_mv) inside {[16'h13:16'h15]}), 16'h0001);
        check("still switching", 16'(gate.tristate), 16'h0000);
        vout_mv = 16'h00C8;
        wait_state(ST_IDLE, 10, cnt);
        cycles(3);
        check("tristate", 16'(gate), 16'h0001);
        $display("test shutdown done");
        finish_test();
    end
endmodule : tb_buck_startup_shutdown_sequencer
